// *** hdl/fabt_core.sv ***
// Fault and alert aggregation, daisy chain and cell balance safety timer
`timescale 1ns/1ps
module fabt_core
  import fabt_pkg::*;
#(
  parameter int OT_HOLD_CYC = OT_HOLD_DFLT,
  parameter int CYC_PER_SEC = SEC_DFLT
)
(
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  input  wire logic        WE_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  output logic             ACK_O,
  input  wire fabt_pins_t  PINS,
  output logic             FAULT_S,
  output logic             FAULT_H,
  output logic             ALERT_S,
  output logic             ALERT_H,
  output logic      [5:0]  CB_O
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  fabt_pins_t meta_ff;
  fabt_pins_t pin_ff;

  // Two stages for every pin input
  always_ff @(posedge MCLK)
    if (!NRST)
    begin
      meta_ff <= '0;
      pin_ff  <= '0;
    end
    else
    begin
      meta_ff <= PINS;
      pin_ff  <= meta_ff;
    end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic       ack_ff;
  logic [7:0] rd_data;
  logic       wr_en;
  logic       wr_flt;
  logic       wr_alr;
  logic       wr_bal;
  logic       wr_time;
  logic       wr_io;
  logic [7:0] wd;

  logic [5:0] flt_ff;
  logic [7:0] alr_ff;
  logic [7:0] bal_ff;
  logic [7:0] per_ff;
  logic       sleep_ff;
  logic       run_ff;

  // Write strobe for one register
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  // Write lands on the edge where the master sees ack
  assign wr_en   = CYC_I && STB_I && WE_I && ack_ff && SEL_I[0];
  assign wd      = DAT_I[7:0];
  assign wr_flt  = wr_en && hit(ADR_I, OFS_FLT_STAT);
  assign wr_alr  = wr_en && hit(ADR_I, OFS_ALR_STAT);
  assign wr_bal  = wr_en && hit(ADR_I, OFS_BAL_CTRL);
  assign wr_time = wr_en && hit(ADR_I, OFS_BAL_TIME);
  assign wr_io   = wr_en && hit(ADR_I, OFS_IO_CTRL);

  // Read mux; unmapped reads zero
  always_comb
  begin
    rd_data = 8'h00;
    case (ADR_I)
      OFS_DEV_STAT: rd_data = {5'h00, run_ff, |alr_ff, |flt_ff};
      OFS_FLT_STAT: rd_data = {2'h0, flt_ff};
      OFS_ALR_STAT: rd_data = alr_ff;
      OFS_BAL_CTRL: rd_data = bal_ff;
      OFS_BAL_TIME: rd_data = per_ff;
      OFS_IO_CTRL:  rd_data = {7'h00, sleep_ff};
      default:      rd_data = 8'h00;
    endcase
  end

  // One wait state, ack for one cycle
  always_ff @(posedge MCLK)
    if (!NRST)
    begin
      ack_ff <= 1'b0;
      DAT_O  <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= CYC_I && STB_I && !ack_ff;
      if (CYC_I && STB_I && !ack_ff)
        DAT_O <= {24'h00_0000, rd_data};
    end
  assign ACK_O = ack_ff;

  // ----------------------------------------------------------------
  // Sleep control and overtemp hold-off
  // ----------------------------------------------------------------
  logic [15:0] hold_ff;
  logic        ot_en;

  // Sleep bit, written by software
  always_ff @(posedge MCLK)
    if (!NRST)
      sleep_ff <= 1'b0;
    else if (wr_io)
      sleep_ff <= wd[IO_SLEEP];

  // Comparators masked in sleep and for a while after exit
  always_ff @(posedge MCLK)
    if (!NRST)
      hold_ff <= 16'h0000;
    else if (wr_io && sleep_ff && !wd[IO_SLEEP])
      hold_ff <= 16'(OT_HOLD_CYC);
    else if (hold_ff != 16'h0000)
      hold_ff <= hold_ff - 16'h0001;
  assign ot_en = !sleep_ff && (hold_ff == 16'h0000);

  // ----------------------------------------------------------------
  // Fault and alert status
  // ----------------------------------------------------------------
  logic [5:0] flt_set;
  logic [7:0] alr_set;
  logic [5:0] flt_clr;
  logic [7:0] alr_clr;
  fabt_evt_t  ev;

  assign ev = pin_ff.evt;

  // Set sources: pin events, and the sleep alert on a bus write that changes the sleep bit
  always_comb
  begin
    flt_set            = 6'h00;
    flt_set[FS_MEMERR] = ev.mem_uncorr;
    flt_set[FS_CRC]    = ev.crc_fail;
    flt_set[FS_UV]     = ev.undervoltage_flag;
    flt_set[FS_OV]     = ev.overvoltage_flag;
    alr_set            = 8'h00;
    alr_set[AS_ADDR]   = ev.address_invalid_flag;
    alr_set[AS_PARITY] = ev.parity_err;
    alr_set[AS_ECCCOR] = ev.memory_corrected_flag;
    alr_set[AS_TSD]    = ev.thermal_shutdown_flag;
    alr_set[AS_SLEEP]  = wr_io && (wd[IO_SLEEP] != sleep_ff);
    alr_set[AS_OT2]    = ev.overtemp_two_flag && ot_en;
    alr_set[AS_OT1]    = ev.overtemp_one_flag && ot_en;
  end

  // Write one to clear, only from the bus
  assign flt_clr = wr_flt ? wd[5:0] : 6'h00;
  assign alr_clr = wr_alr ? wd : 8'h00;

  // Latched fault flags; set beats clear; force written directly
  always_ff @(posedge MCLK)
    if (!NRST)
      flt_ff <= FLT_RST;
    else
    begin
      flt_ff <= (flt_ff & ~flt_clr) | flt_set;
      if (wr_flt)
        flt_ff[FS_FORCE] <= wd[FS_FORCE];
    end

  // Latched alert flags; set beats clear; force written directly
  always_ff @(posedge MCLK)
    if (!NRST)
      alr_ff <= ALR_RST;
    else
    begin
      alr_ff <= (alr_ff & ~alr_clr) | alr_set;
      if (wr_alr)
        alr_ff[AS_FORCE] <= wd[AS_FORCE];
    end

  // ----------------------------------------------------------------
  // Chain outputs
  // ----------------------------------------------------------------
  logic flt_out;
  logic alr_out;

  assign flt_out = pin_ff.fault_north || |(flt_ff & FLT_PIN_MASK);
  assign alr_out = pin_ff.alert_north || |alr_ff;

  // Active high, steered by host select
  always_ff @(posedge MCLK)
    if (!NRST)
    begin
      FAULT_S <= 1'b0;
      FAULT_H <= 1'b0;
      ALERT_S <= 1'b0;
      ALERT_H <= 1'b0;
    end
    else
    begin
      FAULT_S <= flt_out && pin_ff.host_sel;
      FAULT_H <= flt_out && !pin_ff.host_sel;
      ALERT_S <= alr_out && pin_ff.host_sel;
      ALERT_H <= alr_out && !pin_ff.host_sel;
    end

  // ----------------------------------------------------------------
  // Balance control and safety timer
  // ----------------------------------------------------------------
  logic [31:0] sec_ff;
  logic [5:0]  min_ff;
  logic [7:0]  cnt_ff;
  logic        sec_tick;
  logic        unit_tick;
  logic        start;
  logic        stop;
  logic        expire;

  // Control and period registers
  always_ff @(posedge MCLK)
    if (!NRST)
    begin
      bal_ff <= BAL_RST;
      per_ff <= TIME_RST;
    end
    else
    begin
      if (wr_bal)
        bal_ff <= wd;
      if (wr_time)
        per_ff <= wd;
    end

  assign start  = wr_bal && (bal_ff[5:0] == 6'h00) && (wd[5:0] != 6'h00);
  assign stop   = wr_bal && (wd[5:0] == 6'h00);
  assign sec_tick  = (sec_ff == 32'(CYC_PER_SEC - 1));
  assign unit_tick = sec_tick && (!bal_ff[BC_MINUTES] || (min_ff == SEC_PER_MIN - 6'h01));
  assign expire = run_ff && ((per_ff == 8'h00) || (unit_tick && (cnt_ff + 8'h01 >= per_ff)));

  // Seconds and minutes prescalers, restarted with the timer
  always_ff @(posedge MCLK)
    if (!NRST || start || !run_ff)
    begin
      sec_ff <= 32'h0000_0000;
      min_ff <= 6'h00;
    end
    else if (sec_tick)
    begin
      sec_ff <= 32'h0000_0000;
      min_ff <= unit_tick ? 6'h00 : min_ff + 6'h01;
    end
    else
      sec_ff <= sec_ff + 32'h0000_0001;

  // Elapsed units and running flag
  always_ff @(posedge MCLK)
    if (!NRST)
    begin
      run_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end
    else if (start)
    begin
      run_ff <= 1'b1;
      cnt_ff <= 8'h00;
    end
    else if (stop || expire)
    begin
      run_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end
    else if (run_ff && unit_tick)
      cnt_ff <= cnt_ff + 8'h01;

  // Outputs mirror control bits while timer permits
  always_ff @(posedge MCLK)
    if (!NRST)
      CB_O <= 6'h00;
    else
      CB_O <= (run_ff && !expire && per_ff != 8'h00) ? bal_ff[5:0] : 6'h00;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  property p_fault_chain;
    pin_ff.fault_north && pin_ff.host_sel |=> FAULT_S && !FAULT_H;
  endproperty
  a_fault_chain: assert property (p_fault_chain) else $error("north fault not passed south");

  property p_base_route;
    pin_ff.alert_north && !pin_ff.host_sel |=> ALERT_H && !ALERT_S;
  endproperty
  a_base_route: assert property (p_base_route) else $error("base device did not route to host");

  property p_crc_nopin;
    ((flt_ff & FLT_PIN_MASK) == 6'h00) && !pin_ff.fault_north |=> !FAULT_S && !FAULT_H;
  endproperty
  a_crc_nopin: assert property (p_crc_nopin) else $error("fault pin without pin source");

  property p_latch_hold;
    !wr_flt |=> ((flt_ff & $past(flt_ff)) == $past(flt_ff));
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("fault flag cleared without write");

  property p_force_write;
    wr_alr |=> alr_ff[AS_FORCE] == $past(wd[AS_FORCE]);
  endproperty
  a_force_write: assert property (p_force_write) else $error("force bit not written directly");

  property p_ot_hold;
    wr_io && sleep_ff && !wd[IO_SLEEP] |=> !ot_en [*8];
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("overtemp enabled right after sleep exit");

  property p_restart;
    start |=> run_ff && cnt_ff == 8'h00 && sec_ff == 32'h0000_0000;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted");

  property p_no_restart;
    wr_bal && run_ff && bal_ff[5:0] != 6'h00 && wd[5:0] != 6'h00 && !expire |=>
      run_ff && cnt_ff == $past(cnt_ff) + ($past(unit_tick) ? 8'h01 : 8'h00) &&
      sec_ff == ($past(sec_tick) ? 32'h0000_0000 : $past(sec_ff) + 32'h0000_0001);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("timer restarted on non-zero change");

  property p_expire_off;
    expire |=> CB_O == 6'h00 && !run_ff;
  endproperty
  a_expire_off: assert property (p_expire_off) else $error("outputs on after expiry");

  property p_zero_period;
    CB_O != 6'h00 |-> $past(per_ff) != 8'h00 && $past(run_ff);
  endproperty
  a_zero_period: assert property (p_zero_period) else $error("balance on with zero period");

  c_force_fault: cover property (wr_flt && wd[FS_FORCE] ##[1:3] (FAULT_S || FAULT_H));
  c_expire:      cover property (expire);
  c_sleep_exit:  cover property (wr_io && sleep_ff && !wd[IO_SLEEP]);
  c_restart:     cover property (stop ##[1:20] start);

endmodule : fabt_core

// *** hdl/fabt_pkg.sv ***
// Constants, register map and carrier types of the fault, alert and balance timer block
package fabt_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ        = 40_000_000;
  localparam longint OT_HOLD_US    = 200;
  localparam int     OT_HOLD_DFLT  = int'((OT_HOLD_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
  localparam int     SEC_DFLT      = int'(CLK_HZ);
  localparam logic [5:0] SEC_PER_MIN = 6'h3c;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DEV_STAT  = 8'h00;
  localparam logic [7:0] OFS_FLT_STAT  = 8'h04;
  localparam logic [7:0] OFS_ALR_STAT  = 8'h08;
  localparam logic [7:0] OFS_BAL_CTRL  = 8'h0c;
  localparam logic [7:0] OFS_BAL_TIME  = 8'h10;
  localparam logic [7:0] OFS_IO_CTRL   = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DS_FAULT   = 0;
  localparam int DS_ALERT   = 1;
  localparam int DS_CBT     = 2;
  localparam int FS_MEMERR  = 0;
  localparam int FS_FORCE   = 1;
  localparam int FS_POR     = 2;
  localparam int FS_CRC     = 3;
  localparam int FS_UV      = 4;
  localparam int FS_OV      = 5;
  localparam int AS_ADDR    = 0;
  localparam int AS_PARITY  = 1;
  localparam int AS_ECCCOR  = 2;
  localparam int AS_FORCE   = 3;
  localparam int AS_TSD     = 4;
  localparam int AS_SLEEP   = 5;
  localparam int AS_OT2     = 6;
  localparam int AS_OT1     = 7;
  localparam int BC_MINUTES = 7;
  localparam int IO_SLEEP   = 0;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [5:0] FLT_RST      = 6'h04;
  localparam logic [5:0] FLT_PIN_MASK = 6'h37;
  localparam logic [7:0] ALR_RST      = 8'h00;
  localparam logic [7:0] BAL_RST      = 8'h00;
  localparam logic [7:0] TIME_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mem_uncorr;
    logic crc_fail;
    logic undervoltage_flag;
    logic overvoltage_flag;
    logic address_invalid_flag;
    logic parity_err;
    logic memory_corrected_flag;
    logic thermal_shutdown_flag;
    logic overtemp_one_flag;
    logic overtemp_two_flag;
  } fabt_evt_t;

  typedef struct packed {
    logic      fault_north;
    logic      alert_north;
    logic      host_sel;
    fabt_evt_t evt;
  } fabt_pins_t;

endpackage : fabt_pkg

// *** sim/fabt_chain_model.sv ***
// Model of the neighbouring device above and of the board straps
`timescale 1ns/1ps
module fabt_chain_model
  import fabt_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      force_flt,
  input  wire logic      force_alr,
  input  wire logic      base_dev,
  input  wire fabt_evt_t evt_in,
  output fabt_pins_t     pins
);
  // Idle chain lines stay low from time zero
  fabt_pins_t drv = '0;

  assign pins = drv;

  // Upper device drives its south lines from its forced bits
  always @(posedge mclk)
  begin
    drv.fault_north <= force_flt;
    drv.alert_north <= force_alr;
    drv.host_sel    <= ~base_dev;
    drv.evt         <= evt_in;
  end
endmodule : fabt_chain_model

// *** sim/tb.sv ***
// Self-checking bench for the fault, alert and balance timer block
`timescale 1ns/1ps
module tb;
  import fabt_pkg::*;
  localparam int SEC_CYC  = 10;
  localparam int HOLD_CYC = 16;
  logic        mclk;
  logic        nrst  = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic        we    = 1'b0;
  logic [3:0]  sel   = 4'h0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        ack;
  fabt_pins_t  pins;
  logic        f_s, f_h, a_s, a_h;
  logic [5:0]  bal_o;
  logic        frc_f = 1'b0;
  logic        frc_a = 1'b0;
  logic        base  = 1'b1;
  fabt_evt_t   evt   = '0;
  logic [31:0] rd_q[$];
  logic [9:0]  pin_q[$];
  int          fails      = 0;
  int          num_checks = 0;
  int          now        = 0;
  int          t0;
  logic [5:0]  p, q;
  logic [7:0]  ofs;
  logic [15:0] tbl[10] = '{16'h0840, 16'h0880, 16'h0810, 16'h0804, 16'h0802,
                           16'h0801, 16'h0420, 16'h0410, 16'h0408, 16'h0401};

  fabt_core #(.OT_HOLD_CYC(HOLD_CYC), .CYC_PER_SEC(SEC_CYC)) dut_u (
    .MCLK(mclk), .NRST(nrst), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r), .WE_I(we),
    .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .PINS(pins), .FAULT_S(f_s),
    .FAULT_H(f_h), .ALERT_S(a_s), .ALERT_H(a_h), .CB_O(bal_o));
  fabt_chain_model nbr_u (.mclk(mclk), .force_flt(frc_f), .force_alr(frc_a),
    .base_dev(base), .evt_in(evt), .pins(pins));

  // Clock and cycle counter
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) now <= now + 1;

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // Watcher takes the oldest note whenever a result shows
  always @(posedge mclk)
  begin
    if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
      chk(dat_r, rd_q.pop_front());
    if (pin_q.size() > 0)
      chk({22'h0, f_s, f_h, a_s, a_h, bal_o}, {22'h0, pin_q.pop_front()});
  end

  // ----------------------------------------------------------------
  // Bus and pin tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= 4'h1;
    dat_w <= {24'h0, d};
    @(posedge mclk);
    while (ack !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge mclk);
    end
    if (n >= 50)
    begin
      fails++;
      give_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  task automatic wt_to(input int t);
    while (now < t) @(posedge mclk);
  endtask : wt_to

  // Pin vector is {south fault, host fault, south alert, host alert, balance}
  task automatic pin(input logic [9:0] e);
    wt(2);
    @(negedge mclk);
    pin_q.push_back(e);
    @(posedge mclk);
  endtask : pin

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h2701d9c8));
    wt(20);
    nrst <= 1'b1;
    rd(OFS_FLT_STAT, 8'h04);
    pin(10'h100);
    rd(OFS_DEV_STAT, 8'h01);
    rd(OFS_ALR_STAT, 8'h00);
    rd(OFS_BAL_CTRL, 8'h00);
    rd(8'h18, 8'h00);
    wr(OFS_FLT_STAT, 8'h04);
    rd(OFS_FLT_STAT, 8'h00);
    pin(10'h000);
    $display("reset test done");
    base  <= 1'b0;
    frc_f <= 1'b1;
    wt(6);
    pin(10'h200);
    frc_a <= 1'b1;
    wt(6);
    pin(10'h280);
    base <= 1'b1;
    wt(6);
    pin(10'h140);
    frc_f <= 1'b0;
    frc_a <= 1'b0;
    base  <= 1'b0;
    wt(6);
    pin(10'h000);
    $display("chain test done");
    for (int k = 0; k < 2; k++)
    begin
      ofs = (k == 0) ? OFS_FLT_STAT : OFS_ALR_STAT;
      wr(ofs, (k == 0) ? 8'h02 : 8'h08);
      rd(ofs, (k == 0) ? 8'h02 : 8'h08);
      rd(OFS_DEV_STAT, (k == 0) ? 8'h01 : 8'h02);
      pin((k == 0) ? 10'h200 : 10'h080);
      wr(ofs, 8'hff);
      rd(ofs, (k == 0) ? 8'h02 : 8'h08);
      wr(ofs, 8'h00);
      rd(ofs, 8'h00);
      pin(10'h000);
    end
    $display("force test done");
    for (int i = 0; i < 10; i++)
    begin
      ofs = tbl[i][15:8];
      evt <= fabt_evt_t'(10'h1 << i);
      wt(2 + $urandom_range(3));
      evt <= '0;
      wt(6);
      rd(ofs, tbl[i][7:0]);
      rd(OFS_DEV_STAT, (ofs == OFS_FLT_STAT) ? 8'h01 : 8'h02);
      pin((i == 8) ? 10'h000 : (ofs == OFS_FLT_STAT) ? 10'h200 : 10'h080);
      wr(ofs, tbl[i][7:0]);
      rd(ofs, 8'h00);
    end
    $display("event test done");
    wr(OFS_IO_CTRL, 8'h01);
    rd(OFS_ALR_STAT, 8'h20);
    wr(OFS_ALR_STAT, 8'h20);
    wr(OFS_IO_CTRL, 8'h00);
    evt.overtemp_one_flag <= 1'b1;
    wt(4);
    evt <= '0;
    wt(6);
    rd(OFS_ALR_STAT, 8'h20);
    wr(OFS_ALR_STAT, 8'hf7);
    rd(OFS_ALR_STAT, 8'h00);
    $display("sleep test done");
    p = 6'($urandom_range(63, 1));
    q = (p == 6'h3f) ? 6'h01 : ~p;
    wr(OFS_BAL_TIME, 8'h03);
    wr(OFS_BAL_CTRL, {2'b00, p});
    t0 = now;
    pin({4'h0, p});
    rd(OFS_DEV_STAT, 8'h04);
    wt_to(t0 + 15);
    wr(OFS_BAL_CTRL, {2'b00, q});
    pin({4'h0, q});
    wt_to(t0 + 35);
    pin(10'h000);
    rd(OFS_DEV_STAT, 8'h00);
    rd(OFS_BAL_CTRL, {2'b00, q});
    wr(OFS_BAL_CTRL, 8'h00);
    wr(OFS_BAL_CTRL, {2'b00, p});
    t0 = now;
    wt_to(t0 + 20);
    wr(OFS_BAL_CTRL, 8'h00);
    wr(OFS_BAL_CTRL, {2'b00, p});
    t0 = now;
    wt_to(t0 + 25);
    pin({4'h0, p});
    wt_to(t0 + 35);
    pin(10'h000);
    wr(OFS_BAL_CTRL, 8'h00);
    wr(OFS_BAL_TIME, 8'h01);
    wr(OFS_BAL_CTRL, {2'b10, p});
    t0 = now;
    wt_to(t0 + 40);
    pin({4'h0, p});
    rd(OFS_DEV_STAT, 8'h04);
    wt_to(t0 + 620);
    pin(10'h000);
    wr(OFS_BAL_CTRL, 8'h00);
    wr(OFS_BAL_TIME, 8'h03);
    wr(OFS_BAL_CTRL, {2'b00, p});
    wr(OFS_BAL_TIME, 8'h00);
    pin(10'h000);
    rd(OFS_DEV_STAT, 8'h00);
    wr(OFS_BAL_CTRL, 8'h00);
    wr(OFS_BAL_CTRL, {2'b00, p});
    pin(10'h000);
    wr(OFS_BAL_TIME, 8'h03);
    wr(OFS_BAL_CTRL, 8'h00);
    wr(OFS_BAL_CTRL, {2'b00, p});
    pin({4'h0, p});
    wr(OFS_BAL_CTRL, 8'h00);
    pin(10'h000);
    rd(OFS_DEV_STAT, 8'h00);
    $display("balance test done");
    give_verdict();
  end
endmodule : tb
